//--- logic/lcg_gate.sv
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
// Function
// - Normal mode: extended I/O at 0x60..0xFF
// - Extended I/O reached only by data access
// - Legacy I/O addresses identical in both modes
// - Legacy mode: no extended I/O, RAM moved
// - Legacy mode: extended vectors removed
// - Legacy mode: one async port, 8-bit divisor
// - Legacy mode: one 16-bit timer, two compares
// - Legacy mode: two-wire interface disabled
// - Legacy mode: port C output only
// - Legacy mode: port G alternate functions only
// - Legacy mode: port F input only
// - Legacy mode: boot loader disabled
// - Legacy mode: oscillator trim writes ignored
// - Legacy mode: no pin release, no split waits
// - Legacy mode: only external and power-on flags
// - Legacy mode: watchdog change needs no unlock
// - Legacy mode: interrupts 3..0 level only
// - Legacy mode: no receive FIFO
// - Fuse starts programmed, legacy mode
module lcg_gate (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic legacy_compat_fuse,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire lcg_pkg::lcg_core_req_t core_req,
	input wire logic [4:0] reset_src,
	output lcg_pkg::lcg_map_t core_map,
	output lcg_pkg::lcg_gate_t gate,
	output logic compat_mode
);
	import lcg_pkg::*;

	// ----------------------------------------
	// Fuse capture
	// ----------------------------------------

	logic fuse_s1_q;
	logic fuse_s2_q;
	logic [1:0] settle_q;
	logic mode_q;
	logic latched_q;

	// Two-stage synchroniser; the fuse pin is outside the clock domain
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			fuse_s1_q <= LCG_FUSE_RESET;
			fuse_s2_q <= LCG_FUSE_RESET;
		end else begin
			fuse_s1_q <= legacy_compat_fuse;
			fuse_s2_q <= fuse_s1_q;
		end
	end

	// Wait for the synchroniser to fill, then take the fuse once
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			settle_q <= 2'h0;
			latched_q <= 1'b0;
			mode_q <= LCG_FUSE_RESET;
		end else if (!latched_q) begin
			if (settle_q == 2'(LCG_FUSE_SETTLE_CYC)) begin
				mode_q <= fuse_s2_q;
				latched_q <= 1'b1;
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	// Later fuse changes are ignored until the next reset
	assign compat_mode = mode_q;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------

	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] addr_q;
	logic ready_q;
	logic resp_q;
	logic [31:0] rdata_q;
	logic take;
	logic wr_now;

	assign take = hsel && htrans[1] && hready;
	assign wr_now = wr_pend_q;

	// Address phase capture; reads cost one wait state so the
	// read mux always sees a committed write from just before
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
			ready_q <= 1'b1;
		end else begin
			wr_pend_q <= take && hwrite;
			rd_pend_q <= take && !hwrite;
			ready_q <= !(take && !hwrite);
			if (take) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	// Always OKAY, even for unmapped offsets
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			resp_q <= 1'b0;
		end else begin
			resp_q <= 1'b0;
		end
	end

	assign hreadyout = ready_q;
	assign hresp = resp_q;
	assign hrdata = rdata_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction : hit

	// ----------------------------------------
	// Software settings
	// ----------------------------------------

	logic [7:0] portc_sw_q;
	logic [7:0] portf_sw_q;
	logic [4:0] portg_sw_q;
	logic [11:0] baud_q;
	logic sync_sw_q;
	logic usart1_sw_q;
	logic [7:0] osc_cal_q;
	logic [2:0] xrel_sw_q;
	logic split_sw_q;
	logic boot_sw_q;
	logic twi_sw_q;
	logic t3_sw_q;
	logic [7:0] eint_sw_q;

	// Port direction and peripheral enable words
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			portc_sw_q <= 8'h00;
			portf_sw_q <= 8'h00;
			portg_sw_q <= 5'h00;
			xrel_sw_q <= 3'h0;
			split_sw_q <= 1'b0;
			boot_sw_q <= 1'b0;
			twi_sw_q <= 1'b0;
			t3_sw_q <= 1'b0;
			eint_sw_q <= 8'h00;
		end else if (wr_now) begin
			if (hit(addr_q, LCG_PORTDIR_OFS)) begin
				portc_sw_q <= hwdata[7:0];
				portf_sw_q <= hwdata[15:8];
				portg_sw_q <= hwdata[20:16];
			end
			if (hit(addr_q, LCG_PERIPH_OFS)) begin
				xrel_sw_q <= hwdata[2:0];
				split_sw_q <= hwdata[3];
				boot_sw_q <= hwdata[4];
				twi_sw_q <= hwdata[5];
				t3_sw_q <= hwdata[6];
			end
			if (hit(addr_q, LCG_EXTINT_OFS)) begin
				eint_sw_q <= hwdata[7:0];
			end
		end
	end

	// Serial divisor: upper bits never take a write in legacy mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			baud_q <= 12'h000;
			sync_sw_q <= 1'b0;
			usart1_sw_q <= 1'b0;
		end else if (wr_now && hit(addr_q, LCG_SERIAL_OFS)) begin
			baud_q[7:0] <= hwdata[7:0];
			baud_q[11:8] <= mode_q ? 4'h0 : hwdata[11:8];
			sync_sw_q <= hwdata[12];
			usart1_sw_q <= hwdata[13];
		end
	end

	// Oscillator trim holds its reset value in legacy mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			osc_cal_q <= LCG_OSCCAL_RESET;
		end else if (wr_now && hit(addr_q, LCG_OSCCAL_OFS) && !mode_q) begin
			osc_cal_q <= hwdata[7:0];
		end
	end

	// ----------------------------------------
	// Watchdog timeout change
	// ----------------------------------------

	logic [2:0] wdt_to_q;
	logic [2:0] win_q;
	logic wdt_wr;
	logic unlock_wr;

	// Unlock is bit 4 and bit 3 written together
	assign wdt_wr = wr_now && hit(addr_q, LCG_WDT_OFS);
	assign unlock_wr = wdt_wr && hwdata[4] && hwdata[3];

	// Normal mode: a timeout write lands only inside the window that
	// an unlock write opens; legacy mode takes any write
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wdt_to_q <= LCG_WDT_TO_RESET;
			win_q <= 3'h0;
		end else begin
			if (unlock_wr && !mode_q) begin
				win_q <= 3'(LCG_WDT_WIN_CYC);
			end else if (win_q != 3'h0) begin
				win_q <= win_q - 3'h1;
			end
			if (wdt_wr && mode_q) begin
				wdt_to_q <= hwdata[2:0];
			end else if (wdt_wr && !unlock_wr && win_q != 3'h0) begin
				wdt_to_q <= hwdata[2:0];
				win_q <= 3'h0;
			end
		end
	end

	// ----------------------------------------
	// Reset cause flags
	// ----------------------------------------

	logic [4:0] rc_q;
	logic [4:0] rc_mask;
	logic [4:0] rc_clr;
	logic [4:0] rc_legacy;

	// Surviving flags placed by their package bit positions
	always_comb begin
		rc_legacy = 5'h00;
		rc_legacy[LCG_RC_POR] = 1'b1;
		rc_legacy[LCG_RC_EXT] = 1'b1;
	end

	// Legacy mode keeps only the external and power-on sources
	assign rc_mask = mode_q ? rc_legacy : 5'h1F;
	assign rc_clr = (wr_now && hit(addr_q, LCG_RSTCAUSE_OFS)) ? hwdata[4:0] : 5'h00;

	// Write one to clear; a new event wins over the clear
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rc_q <= 5'h00;
		end else begin
			rc_q <= ((rc_q & ~rc_clr) | reset_src) & rc_mask;
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------

	// Unused bits read as zero
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 32'h00000000;
		end else if (rd_pend_q) begin
			if (hit(addr_q, LCG_STATUS_OFS)) begin
				rdata_q <= {16'h0000, 2'h0, gate.vec_count, 6'h00, latched_q, mode_q};
			end else if (hit(addr_q, LCG_PORTDIR_OFS)) begin
				rdata_q <= {11'h000, portg_sw_q, portf_sw_q, portc_sw_q};
			end else if (hit(addr_q, LCG_SERIAL_OFS)) begin
				rdata_q <= {18'h00000, usart1_sw_q, sync_sw_q, baud_q};
			end else if (hit(addr_q, LCG_OSCCAL_OFS)) begin
				rdata_q <= {24'h000000, osc_cal_q};
			end else if (hit(addr_q, LCG_PERIPH_OFS)) begin
				rdata_q <= {25'h0000000, t3_sw_q, twi_sw_q, boot_sw_q, split_sw_q, xrel_sw_q};
			end else if (hit(addr_q, LCG_WDT_OFS)) begin
				rdata_q <= {29'h00000000, wdt_to_q};
			end else if (hit(addr_q, LCG_RSTCAUSE_OFS)) begin
				rdata_q <= {27'h0000000, rc_q};
			end else if (hit(addr_q, LCG_EXTINT_OFS)) begin
				rdata_q <= {24'h000000, eint_sw_q};
			end else begin
				rdata_q <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Gated controls to the peripherals
	// ----------------------------------------

	// Registered so every control toggles cleanly one edge after
	// the mode or the setting changes
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gate <= '0;
		end else begin
			gate.ext_io_en <= !mode_q;
			gate.ext_vec_en <= !mode_q;
			gate.vec_count <= mode_q ? LCG_VEC_LEGACY : LCG_VEC_NORMAL;
			gate.usart1_en <= usart1_sw_q && !mode_q;
			gate.usart_sync_ok <= sync_sw_q && !mode_q;
			gate.baud_div <= mode_q ? {4'h0, baud_q[7:0]} : baud_q;
			gate.timer3_en <= t3_sw_q && !mode_q;
			gate.cmp_count <= mode_q ? LCG_CMP_LEGACY : LCG_CMP_NORMAL;
			gate.twi_en <= twi_sw_q && !mode_q;
			gate.portc_dir <= mode_q ? 8'hFF : portc_sw_q;
			gate.portf_dir <= mode_q ? 8'h00 : portf_sw_q;
			gate.portg_gpio_en <= mode_q ? 5'h00 : portg_sw_q;
			gate.boot_en <= boot_sw_q && !mode_q;
			gate.osc_cal <= osc_cal_q;
			gate.xmem_release <= mode_q ? 3'h0 : xrel_sw_q;
			gate.xmem_split_ws <= split_sw_q && !mode_q;
			gate.wdt_timeout <= wdt_to_q;
			gate.ext_int_sense <= mode_q ? 8'h00 : eint_sw_q;
			gate.rx_fifo_depth <= mode_q ? LCG_RXFIFO_LEGACY : LCG_RXFIFO_NORMAL;
			gate.ram_base <= mode_q ? LCG_RAM_BASE_LEGACY : LCG_RAM_BASE_NORMAL;
		end
	end

	// ----------------------------------------
	// Core access decode
	// ----------------------------------------

	function automatic lcg_map_t classify(input lcg_core_req_t r, input logic legacy);
		lcg_map_t m;
		m = '0;
		if (r.io_instr) begin
			// Short I/O opcodes only ever reach the first 64 slots
			m.legacy_io = (r.addr[15:6] == 10'h000);
			m.data_addr = LCG_IO_BASE + {10'h000, r.addr[5:0]};
		end else begin
			m.data_addr = r.addr;
			if (r.addr >= LCG_IO_BASE && r.addr < LCG_EXT_IO_LO) begin
				m.legacy_io = 1'b1;
			end else if (r.addr >= LCG_EXT_IO_LO && r.addr <= LCG_EXT_IO_HI && !legacy) begin
				m.ext_io = 1'b1;
			end else if (r.addr >= (legacy ? LCG_RAM_BASE_LEGACY : LCG_RAM_BASE_NORMAL)) begin
				m.ram = 1'b1;
			end
		end
		classify = m;
	endfunction : classify

	// Decode registered; idle cycles present an empty map
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			core_map <= '0;
		end else if (core_req.valid) begin
			core_map <= classify(core_req, mode_q);
		end else begin
			core_map <= '0;
		end
	end

	// Software is expected to write zero to unused bits; the upper
	// bits of each register are simply not stored, so they read zero

endmodule : lcg_gate

//--- logic/lcg_pkg.sv
package lcg_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] LCG_STATUS_OFS = 8'h00;
	localparam logic [7:0] LCG_PORTDIR_OFS = 8'h04;
	localparam logic [7:0] LCG_SERIAL_OFS = 8'h08;
	localparam logic [7:0] LCG_OSCCAL_OFS = 8'h0C;
	localparam logic [7:0] LCG_PERIPH_OFS = 8'h10;
	localparam logic [7:0] LCG_WDT_OFS = 8'h14;
	localparam logic [7:0] LCG_RSTCAUSE_OFS = 8'h18;
	localparam logic [7:0] LCG_EXTINT_OFS = 8'h1C;

	// ----------------------------------------
	// Data space layout
	// ----------------------------------------
	localparam logic [15:0] LCG_IO_BASE = 16'h0020;
	localparam logic [15:0] LCG_EXT_IO_LO = 16'h0060;
	localparam logic [15:0] LCG_EXT_IO_HI = 16'h00FF;
	localparam logic [15:0] LCG_RAM_BASE_NORMAL = 16'h0100;
	localparam logic [15:0] LCG_RAM_BASE_LEGACY = 16'h0060;
	localparam logic [5:0] LCG_IO_LAST = 6'h3F;

	// ----------------------------------------
	// Vector counts, timer compares, FIFO depths
	// ----------------------------------------
	localparam logic [5:0] LCG_VEC_NORMAL = 6'h23;
	localparam logic [5:0] LCG_VEC_LEGACY = 6'h18;
	localparam logic [1:0] LCG_CMP_NORMAL = 2'h3;
	localparam logic [1:0] LCG_CMP_LEGACY = 2'h2;
	localparam logic [1:0] LCG_RXFIFO_NORMAL = 2'h2;
	localparam logic [1:0] LCG_RXFIFO_LEGACY = 2'h1;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic LCG_FUSE_RESET = 1'b1;
	localparam logic [7:0] LCG_OSCCAL_RESET = 8'h80;
	localparam logic [2:0] LCG_WDT_TO_RESET = 3'h0;
	localparam int LCG_CLK_MHZ = 25;
	localparam int LCG_WDT_WIN_CYC = 4;
	localparam int LCG_FUSE_SETTLE_CYC = 2;

	// Reset cause bit positions
	localparam int LCG_RC_POR = 0;
	localparam int LCG_RC_EXT = 1;
	localparam int LCG_RC_BOD = 2;
	localparam int LCG_RC_WDT = 3;
	localparam int LCG_RC_JTAG = 4;

	typedef struct packed {
		logic valid;
		logic io_instr;
		logic [15:0] addr;
	} lcg_core_req_t;

	typedef struct packed {
		logic legacy_io;
		logic ext_io;
		logic ram;
		logic [15:0] data_addr;
	} lcg_map_t;

	typedef struct packed {
		logic ext_io_en;
		logic ext_vec_en;
		logic [5:0] vec_count;
		logic usart1_en;
		logic usart_sync_ok;
		logic [11:0] baud_div;
		logic timer3_en;
		logic [1:0] cmp_count;
		logic twi_en;
		logic [7:0] portc_dir;
		logic [7:0] portf_dir;
		logic [4:0] portg_gpio_en;
		logic boot_en;
		logic [7:0] osc_cal;
		logic [2:0] xmem_release;
		logic xmem_split_ws;
		logic [2:0] wdt_timeout;
		logic [7:0] ext_int_sense;
		logic [1:0] rx_fifo_depth;
		logic [15:0] ram_base;
	} lcg_gate_t;

endpackage : lcg_pkg

//--- testbench/lcg_gate_monitor.sv
`timescale 1ns/10ps
// ----
// Gating checker
// ----
module lcg_gate_monitor (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire lcg_pkg::lcg_core_req_t core_req,
	input wire lcg_pkg::lcg_map_t core_map,
	input wire lcg_pkg::lcg_gate_t gate,
	input wire logic compat_mode
);
	import lcg_pkg::*;
	logic [2:0] cnt_q;
	logic rd;
	// Edges since reset; saturates so the checks gated on it never disarm by wrapping back to zero
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 3'h0;
		end else if (cnt_q != 3'h7) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	assign rd = hsel & htrans[1] & hready & !hwrite;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	read_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	mode_held_a: assert property (cnt_q >= 3'h4 |-> $stable(compat_mode))
		else $error("mode changed mid-run");
	legacy_ports_a: assert property (compat_mode && cnt_q != 3'h0 |->
		gate.portc_dir == 8'hFF && gate.portf_dir == 8'h00 && gate.portg_gpio_en == 5'h00)
		else $error("legacy port directions wrong");
	legacy_periph_a: assert property (compat_mode && cnt_q != 3'h0 |->
		!gate.usart1_en && !gate.usart_sync_ok && gate.baud_div[11:8] == 4'h0
		&& !gate.timer3_en && gate.cmp_count == 2'h2 && !gate.twi_en && !gate.boot_en)
		else $error("legacy peripheral left enabled");
	legacy_misc_a: assert property (compat_mode && cnt_q != 3'h0 |->
		gate.xmem_release == 3'h0 && !gate.xmem_split_ws && gate.ext_int_sense == 8'h00
		&& gate.rx_fifo_depth == 2'h1)
		else $error("legacy pins, sense or fifo wrong");
	legacy_space_a: assert property (compat_mode && cnt_q != 3'h0 |->
		!gate.ext_io_en && !gate.ext_vec_en && gate.vec_count == 6'h18
		&& gate.ram_base == 16'h0060)
		else $error("legacy layout wrong");
	normal_space_a: assert property (!compat_mode && cnt_q >= 3'h6 |->
		gate.ext_io_en && gate.ram_base == 16'h0100 && gate.vec_count == 6'h23
		&& gate.cmp_count == 2'h3 && gate.rx_fifo_depth == 2'h2)
		else $error("normal layout wrong");
	io_decode_a: assert property (core_req.valid && core_req.io_instr
		&& core_req.addr < 16'h0040 |=> core_map.legacy_io && !core_map.ext_io
		&& core_map.data_addr == $past(core_req.addr[5:0]) + 16'h0020)
		else $error("short io decode wrong");
	ext_decode_a: assert property (core_req.valid && !core_req.io_instr && cnt_q >= 3'h4
		&& core_req.addr inside {[16'h0060:16'h00FF]} |=> core_map.ext_io == !compat_mode)
		else $error("extended io decode wrong");
	idle_decode_a: assert property (!core_req.valid |=> core_map == '0)
		else $error("decode without request");
endmodule : lcg_gate_monitor

//--- testbench/lcg_gate_tb_top.sv
`timescale 1ns/10ps
module lcg_gate_tb_top;
	import lcg_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic legacy_compat_fuse = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	lcg_core_req_t core_req = '0;
	logic [4:0] reset_src = 5'h00;
	lcg_map_t core_map;
	lcg_gate_t gate;
	logic compat_mode;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h00012850;
	logic [31:0] rd_q;

	always #20 clock = ~clock;
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	lcg_gate i_dut (.clock, .sys_rst, .legacy_compat_fuse, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .core_req, .reset_src,
		.core_map, .gate, .compat_mode);

	// ----
	// Helpers
	// ----
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic lcg_map_t exp_map(lcg_core_req_t r, logic leg);
		lcg_map_t m;
		m = '0;
		if (r.valid && r.io_instr) begin
			m.legacy_io = r.addr < 16'h0040;
			m.data_addr = 16'h0020 + {10'h000, r.addr[5:0]};
		end else if (r.valid) begin
			m.data_addr = r.addr;
			m.legacy_io = r.addr inside {[16'h0020:16'h005F]};
			m.ext_io = !leg && (r.addr inside {[16'h0060:16'h00FF]});
			m.ram = r.addr >= (leg ? 16'h0060 : 16'h0100);
		end
		return m;
	endfunction : exp_map

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// Entered just after an edge; returns at the edge that ends the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		rd_q = hrdata;
		chk("resp", 32'(hresp), 32'h0);
	endtask : bus

	// ----
	// One run per fuse setting
	// ----
	task automatic phase(input logic leg);
		logic [31:0] v;
		lcg_core_req_t r;
		logic [15:0] cor [4] = '{16'h005F, 16'h0060, 16'h00FF, 16'h0100};
		sys_rst <= 1'b1;
		legacy_compat_fuse <= leg;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clock);
		chk("mode", 32'(compat_mode), 32'(leg));
		// Fuse flips in mid-run; the mode must ignore it until the next reset
		legacy_compat_fuse <= ~leg;
		repeat (6) @(posedge clock);
		chk("mode held", 32'(compat_mode), 32'(leg));
		bus(1'b0, LCG_STATUS_OFS, 32'h0);
		chk("vectors", 32'(rd_q[13:8]), leg ? 32'h18 : 32'h23);
		v = rnd();
		bus(1'b1, LCG_OSCCAL_OFS, v & 32'h000000FF);
		bus(1'b1, LCG_SERIAL_OFS, (v & 32'h00000FFF) | 32'h3000);
		repeat (2) @(posedge clock);
		chk("trim", 32'(gate.osc_cal), leg ? 32'h80 : 32'(v[7:0]));
		chk("divisor", 32'(gate.baud_div), leg ? 32'(v[7:0]) : 32'(v[11:0]));
		chk("port two", 32'({gate.usart1_en, gate.usart_sync_ok}), leg ? 0 : 32'h3);
		v = rnd();
		bus(1'b1, LCG_PORTDIR_OFS, v & 32'h001FFFFF);
		bus(1'b1, LCG_PERIPH_OFS, 32'h7F);
		bus(1'b1, LCG_EXTINT_OFS, 32'hFF);
		repeat (2) @(posedge clock);
		chk("dirs", 32'({gate.portg_gpio_en, gate.portf_dir, gate.portc_dir}),
			leg ? 32'hFF : {11'h000, v[20:0]});
		chk("periph", 32'({gate.xmem_release, gate.xmem_split_ws, gate.boot_en, gate.twi_en,
			gate.timer3_en}), leg ? 32'h0 : 32'h7F);
		chk("sense", 32'(gate.ext_int_sense), leg ? 32'h0 : 32'hFF);
		// Plain write first, then the unlock and the timed write back to back
		v = {29'h0, 3'(rnd()) | 3'h1};
		bus(1'b1, LCG_WDT_OFS, v);
		repeat (2) @(posedge clock);
		chk("wdt plain", 32'(gate.wdt_timeout), leg ? 32'(v[2:0]) : 32'h0);
		bus(1'b1, LCG_WDT_OFS, 32'h18);
		bus(1'b1, LCG_WDT_OFS, v);
		repeat (2) @(posedge clock);
		chk("wdt timed", 32'(gate.wdt_timeout), 32'(v[2:0]));
		reset_src <= 5'h1F;
		@(posedge clock);
		reset_src <= 5'h00;
		@(posedge clock);
		bus(1'b0, LCG_RSTCAUSE_OFS, 32'h0);
		chk("causes", 32'(rd_q[4:0]), leg ? 32'h3 : 32'h1F);
		bus(1'b1, LCG_RSTCAUSE_OFS, 32'h1F);
		bus(1'b0, LCG_RSTCAUSE_OFS, 32'h0);
		chk("cleared", 32'(rd_q[4:0]), 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped", rd_q, 32'h0);
		// Boundary addresses first, then random short and data accesses
		for (int i = 0; i < 28; i++) begin
			v = rnd();
			r.valid = i < 4 || v[31] || v[30];
			r.io_instr = i >= 4 && v[29];
			r.addr = (i < 4) ? cor[i] : (v[29] ? {9'h000, v[6:0]} : {7'h00, v[8:0]});
			core_req <= r;
			repeat (2) @(posedge clock);
			chk("decode", 32'(core_map), 32'(exp_map(r, leg)));
		end
		core_req <= '0;
		@(posedge clock);
	endtask : phase

	initial begin
		phase(1'b1);
		phase(1'b0);
		print_verdict();
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			print_verdict();
		end
	end
endmodule : lcg_gate_tb_top

bind lcg_gate lcg_gate_monitor i_mon (.clock, .sys_rst, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .core_req, .core_map, .gate, .compat_mode);
